//--- include/shifter_regs.svh
`ifndef SHIFTER_REGS_SVH
`define SHIFTER_REGS_SVH

// ==========================================================
// register map (byte addresses on the plain register port)
`define CTRL_ADDR       8'h00
`define STATUS_ADDR     8'h04
`define SHIFT_CNT_ADDR  8'h08
`define LATCH_CNT_ADDR  8'h0c

// ==========================================================
// control register fields
`define CTRL_OUT_DIS_BIT  0
`define CTRL_CLEAR_BIT    1
`define CTRL_WIDTH        2
`define CTRL_RESET        2'h0

// ==========================================================
// status register fields
`define STAT_LATCH_LSB    0
`define STAT_STAGE_LSB    8
`define STAT_CLEAR_BIT    16
`define STAT_DRIVE_BIT    17

// ==========================================================
// widths and reset values
`define STAGE_COUNT       8
`define BUS_ADDR_WIDTH    8
`define BUS_DATA_WIDTH    32
`define CNT_WIDTH         16
`define CNT_RESET         16'h0000
`define RDATA_RESET       32'h0000_0000
`define UNMAPPED_READ     32'h0000_0000

// ==========================================================
// bit positions inside the synchronised link-status vector
`define SYNC_SHIFT_TOG    0
`define SYNC_LATCH_TOG    1
`define SYNC_CLEAR        2
`define SYNC_DRIVE        3
`define SYNC_WIDTH        4

`endif

//--- include/shifter_pkg.sv
`include "shifter_regs.svh"

package shifter_pkg;

	typedef logic [`BUS_ADDR_WIDTH-1:0] addr_t;
	typedef logic [`BUS_DATA_WIDTH-1:0] data_t;
	typedef logic [`CNT_WIDTH-1:0]      cnt_t;
	typedef logic [`CTRL_WIDTH-1:0]     ctrl_t;

endpackage

//--- include/sync_if.sv
`timescale 1ns/100ps

interface sync_if #(
	parameter int W = 1
);
	logic [W-1:0] async_d;
	logic [W-1:0] sync_q;

	modport src (
		output async_d,
		input  sync_q
	);

	modport dst (
		input  async_d,
		output sync_q
	);
endinterface

//--- hw/bit_sync.sv
`timescale 1ns/100ps

module bit_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// crossing
	sync_if.dst       sif
);

	// ==========================================================
	// two-flop synchroniser; the first stage feeds only the second
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else if (ce) begin
			meta_ff <= sif.async_d;
			sync_ff <= meta_ff;
		end
	end

	assign sif.sync_q = sync_ff;

endmodule

//--- hw/serial_in_latched_parallel_out_shifter.sv
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/100ps
`include "shifter_regs.svh"


module serial_in_latched_parallel_out_shifter #(
	parameter int W = `STAGE_COUNT
) (
	// system clock, reset, clock enable
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic                        ce,
	// register port
	input  wire shifter_pkg::addr_t          reg_addr,
	input  wire shifter_pkg::data_t          reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output      shifter_pkg::data_t          reg_rdata,
	// link clocks and serial pins
	input  wire logic                        shift_clock_in,
	input  wire logic                        latch_clock_in,
	input  wire logic                        serial_in,
	input  wire logic                        stage_clear_n,
	output      logic                        cascade_out,
	// three-state parallel outputs
	input  wire logic                        drive_enable_n,
	output      logic [W-1:0]                par_out,
	output      logic [W-1:0]                par_out_oe
);

	// ==========================================================
	// address decode
	function automatic logic addr_hit(input shifter_pkg::addr_t a,
		input shifter_pkg::addr_t target);
		addr_hit = (a == target);
	endfunction

	wire hit_ctrl   = addr_hit(reg_addr, `CTRL_ADDR);
	wire hit_status = addr_hit(reg_addr, `STATUS_ADDR);
	wire hit_shcnt  = addr_hit(reg_addr, `SHIFT_CNT_ADDR);
	wire hit_ltcnt  = addr_hit(reg_addr, `LATCH_CNT_ADDR);

	wire wr_ctrl    = reg_wr & hit_ctrl;
	wire wr_shcnt   = reg_wr & hit_shcnt;
	wire wr_ltcnt   = reg_wr & hit_ltcnt;

	// ==========================================================
	// control register
	shifter_pkg::ctrl_t ctrl_ff;
	shifter_pkg::ctrl_t nxt_ctrl;

	assign nxt_ctrl = wr_ctrl ? reg_wdata[`CTRL_WIDTH-1:0] : ctrl_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= `CTRL_RESET;
		end else if (ce) begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	wire soft_out_dis = ctrl_ff[`CTRL_OUT_DIS_BIT];
	wire soft_clear   = ctrl_ff[`CTRL_CLEAR_BIT];

	// ==========================================================
	// shift stages, on the shift clock
	// the clear combines the pin, the software clear and system reset; every
	// term is a pin or a flop output so the combined level does not glitch
	logic [W-1:0] stage_bits_ff;
	logic         shift_tog_ff;

	wire stage_clear_eff_n = stage_clear_n & ~soft_clear & rst_n;

	always_ff @(posedge shift_clock_in or negedge stage_clear_eff_n) begin
		if (!stage_clear_eff_n) begin
			stage_bits_ff <= '0;
		end else begin
			stage_bits_ff <= {stage_bits_ff[W-2:0], serial_in};
		end
	end

	// event marker for the register side; not cleared by the stage clear
	always_ff @(posedge shift_clock_in or negedge rst_n) begin
		if (!rst_n) begin
			shift_tog_ff <= 1'b0;
		end else begin
			shift_tog_ff <= ~shift_tog_ff;
		end
	end

	assign cascade_out = stage_bits_ff[W-1];

	// ==========================================================
	// storage latch, on the latch clock
	// it samples the stages with the clock-to-out of the shift flops, so a
	// shared edge loads the old contents; the host keeps shift-to-latch setup
	logic [W-1:0] latch_bits_ff;
	logic         latch_tog_ff;

	always_ff @(posedge latch_clock_in or negedge rst_n) begin
		if (!rst_n) begin
			latch_bits_ff <= '0;
		end else begin
			latch_bits_ff <= stage_bits_ff;
		end
	end

	always_ff @(posedge latch_clock_in or negedge rst_n) begin
		if (!rst_n) begin
			latch_tog_ff <= 1'b0;
		end else begin
			latch_tog_ff <= ~latch_tog_ff;
		end
	end

	// ==========================================================
	// three-state outputs: data from the latch flops, one enable shared by every bit
	wire drive_on = ~drive_enable_n & ~soft_out_dis;

	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_out
			assign par_out[gi]    = latch_bits_ff[gi];
			assign par_out_oe[gi] = drive_on;
		end
	endgenerate

	// ==========================================================
	// crossings into the system clock
	sync_if #(.W(`SYNC_WIDTH)) link_sif ();

	assign link_sif.async_d[`SYNC_SHIFT_TOG] = shift_tog_ff;
	assign link_sif.async_d[`SYNC_LATCH_TOG] = latch_tog_ff;
	assign link_sif.async_d[`SYNC_CLEAR]     = ~stage_clear_eff_n;
	assign link_sif.async_d[`SYNC_DRIVE]     = ~drive_enable_n;

	bit_sync #(.W(`SYNC_WIDTH)) u_link_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.sif   (link_sif.dst)
	);

	logic shift_seen_ff;
	logic latch_seen_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_seen_ff <= 1'b0;
			latch_seen_ff <= 1'b0;
		end else if (ce) begin
			shift_seen_ff <= link_sif.sync_q[`SYNC_SHIFT_TOG];
			latch_seen_ff <= link_sif.sync_q[`SYNC_LATCH_TOG];
		end
	end

	wire shift_evt    = link_sif.sync_q[`SYNC_SHIFT_TOG] ^ shift_seen_ff;
	wire latch_evt    = link_sif.sync_q[`SYNC_LATCH_TOG] ^ latch_seen_ff;
	wire clear_active = link_sif.sync_q[`SYNC_CLEAR];
	wire drive_pin_on = link_sif.sync_q[`SYNC_DRIVE];

	// ==========================================================
	// snapshots: the words were launched with their toggle and have
	// settled by the time the toggle is seen; a clear zeroes the stage copy only
	logic [W-1:0] stage_snap_ff;
	logic [W-1:0] latch_snap_ff;
	logic [W-1:0] nxt_stage_snap;
	logic [W-1:0] nxt_latch_snap;

	assign nxt_stage_snap = clear_active ? '0 :
		(shift_evt ? stage_bits_ff : stage_snap_ff);
	assign nxt_latch_snap = latch_evt ? latch_bits_ff : latch_snap_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_snap_ff <= '0;
			latch_snap_ff <= '0;
		end else if (ce) begin
			stage_snap_ff <= nxt_stage_snap;
			latch_snap_ff <= nxt_latch_snap;
		end
	end

	// ==========================================================
	// edge counters; an event in the clearing cycle is kept
	shifter_pkg::cnt_t shift_cnt_ff;
	shifter_pkg::cnt_t latch_cnt_ff;
	shifter_pkg::cnt_t nxt_shift_cnt;
	shifter_pkg::cnt_t nxt_latch_cnt;

	assign nxt_shift_cnt = wr_shcnt ? shifter_pkg::cnt_t'(shift_evt) :
		shifter_pkg::cnt_t'(shift_cnt_ff + shifter_pkg::cnt_t'(shift_evt));
	assign nxt_latch_cnt = wr_ltcnt ? shifter_pkg::cnt_t'(latch_evt) :
		shifter_pkg::cnt_t'(latch_cnt_ff + shifter_pkg::cnt_t'(latch_evt));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_cnt_ff <= `CNT_RESET;
			latch_cnt_ff <= `CNT_RESET;
		end else if (ce) begin
			shift_cnt_ff <= nxt_shift_cnt;
			latch_cnt_ff <= nxt_latch_cnt;
		end
	end

	// ==========================================================
	// read data, one cycle after the read strobe, zero otherwise
	shifter_pkg::data_t status_word;
	shifter_pkg::data_t rd_mux;
	shifter_pkg::data_t rdata_ff;
	shifter_pkg::data_t nxt_rdata;

	always_comb begin
		status_word = '0;
		status_word[`STAT_LATCH_LSB +: W] = latch_snap_ff;
		status_word[`STAT_STAGE_LSB +: W] = stage_snap_ff;
		status_word[`STAT_CLEAR_BIT]      = clear_active;
		status_word[`STAT_DRIVE_BIT]      = drive_pin_on & ~soft_out_dis;
	end

	assign rd_mux =
		hit_ctrl   ? shifter_pkg::data_t'(ctrl_ff) :
		hit_status ? status_word :
		hit_shcnt  ? shifter_pkg::data_t'(shift_cnt_ff) :
		hit_ltcnt  ? shifter_pkg::data_t'(latch_cnt_ff) :
		`UNMAPPED_READ;

	assign nxt_rdata = reg_rd ? rd_mux : `RDATA_RESET;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= `RDATA_RESET;
		end else if (ce) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

endmodule

//--- sim/shifter_monitor.sv
`timescale 1ns/100ps
// ========
// port-level checks
module shifter_monitor #(
	parameter int W = 8
) (
	// system
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic               ce,
	// register port
	input wire shifter_pkg::addr_t reg_addr,
	input wire shifter_pkg::data_t reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire shifter_pkg::data_t reg_rdata,
	// link
	input wire logic               shift_clock_in,
	input wire logic               latch_clock_in,
	input wire logic               serial_in,
	input wire logic               stage_clear_n,
	input wire logic               cascade_out,
	// parallel side
	input wire logic               drive_enable_n,
	input wire logic [W-1:0]       par_out,
	input wire logic [W-1:0]       par_out_oe
);
	logic [W-1:0] sr_ff;
	logic [W-1:0] lt_ff;
	logic         dis_ff;
	// reference stages and latch; the latch reads the stages before a coincident shift
	always_ff @(posedge shift_clock_in or negedge rst_n or negedge stage_clear_n)
		if (!rst_n || !stage_clear_n)
			sr_ff <= '0;
		else
			sr_ff <= {sr_ff[W-2:0], serial_in};
	always_ff @(posedge latch_clock_in or negedge rst_n)
		if (!rst_n)
			lt_ff <= '0;
		else
			lt_ff <= sr_ff;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			dis_ff <= 1'b0;
		else if (ce && reg_wr && reg_addr == 8'h00)
			dis_ff <= reg_wdata[0];
	property p_clr_casc;
		@(posedge clk) disable iff (!rst_n) !stage_clear_n |-> !cascade_out;
	endproperty
	a_clr_casc: assert property (p_clr_casc) else $error("cascade high in clear");
	property p_oe_off;
		@(posedge clk) disable iff (!rst_n) drive_enable_n |-> par_out_oe == '0;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("outputs driven");
	property p_oe_on;
		@(posedge clk) disable iff (!rst_n) !drive_enable_n && !dis_ff |-> par_out_oe == '1;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("outputs not driven");
	property p_casc;
		@(posedge clk) disable iff (!rst_n) cascade_out == sr_ff[W-1];
	endproperty
	a_casc: assert property (p_casc) else $error("cascade wrong");
	property p_latch;
		@(posedge clk) disable iff (!rst_n) par_out == lt_ff;
	endproperty
	a_latch: assert property (p_latch) else $error("latch wrong");
	property p_par_stable;
		@(posedge clk) disable iff (!rst_n) $stable(lt_ff) |-> $stable(par_out);
	endproperty
	a_par_stable: assert property (p_par_stable) else $error("outputs moved");
	property p_rd_idle;
		@(posedge clk) disable iff (!rst_n) !$past(reg_rd) |-> reg_rdata == '0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
	property p_unmapped;
		@(posedge clk) disable iff (!rst_n) reg_rd && ce && reg_addr == 8'h10 ##1 1'b1
			|-> reg_rdata == '0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	c_clear: cover property (@(posedge clk) !stage_clear_n);
	c_tied: cover property (@(posedge clk) $rose(latch_clock_in) && $rose(shift_clock_in));
	c_float: cover property (@(posedge clk) drive_enable_n);
endmodule

bind serial_in_latched_parallel_out_shifter shifter_monitor #(.W(W)) u_mon (
	.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.shift_clock_in(shift_clock_in), .latch_clock_in(latch_clock_in),
	.serial_in(serial_in), .stage_clear_n(stage_clear_n), .cascade_out(cascade_out),
	.drive_enable_n(drive_enable_n), .par_out(par_out), .par_out_oe(par_out_oe)
);

//--- sim/host_model.sv
`timescale 1ns/100ps
// ========
// host on the link; clocks rest low between frames
module host_model (
	// link pins
	output logic shift_clock_in,
	output logic latch_clock_in,
	output logic serial_in,
	output logic stage_clear_n
);
	initial begin
		shift_clock_in = 1'b0;
		latch_clock_in = 1'b0;
		serial_in = 1'b0;
		stage_clear_n = 1'b1;
	end
	// msb first; the 1 ns offset keeps link edges off the system clock edges
	task automatic frame(input logic [7:0] v, input logic tie);
		#1;
		for (int i = 7; i >= 0; i--) begin
			serial_in = v[i];
			#32;
			shift_clock_in = 1'b1;
			latch_clock_in = tie;
			#32;
			shift_clock_in = 1'b0;
			latch_clock_in = 1'b0;
			// hold is over, so the line stops showing the bit
			serial_in = ~v[i];
		end
	endtask
	task automatic latch_pulse();
		#33;
		latch_clock_in = 1'b1;
		#32;
		latch_clock_in = 1'b0;
	endtask
	task automatic set_clear(input logic v);
		stage_clear_n = v;
	endtask
endmodule

//--- sim/test_serial_in_latched_parallel_out_shifter.sv
`timescale 1ns/100ps
// ========
// register port and link scenarios
module test_serial_in_latched_parallel_out_shifter;
	logic               clk, rst_n, ce, reg_wr, reg_rd, drive_enable_n, cascade_out;
	logic               shift_clock_in, latch_clock_in, serial_in, stage_clear_n;
	shifter_pkg::addr_t reg_addr;
	shifter_pkg::data_t reg_wdata, reg_rdata;
	logic [7:0]         par_out, par_out_oe;
	int                 num_errors, n_tests;

	host_model host (.shift_clock_in(shift_clock_in), .latch_clock_in(latch_clock_in),
		.serial_in(serial_in), .stage_clear_n(stage_clear_n));
	serial_in_latched_parallel_out_shifter #(.W(8)) dut (.clk(clk), .rst_n(rst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .shift_clock_in(shift_clock_in),
		.latch_clock_in(latch_clock_in), .serial_in(serial_in),
		.stage_clear_n(stage_clear_n), .cascade_out(cascade_out),
		.drive_enable_n(drive_enable_n), .par_out(par_out), .par_out_oe(par_out_oe));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
			num_errors++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		check(reg_rdata, exp);
	endtask
	// status and counters trail the link by up to three cycles
	task automatic settle();
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		test_done();
	end
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		drive_enable_n = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check(par_out_oe, 8'hff);
		rd(8'h00, 32'h0);
		host.frame(8'ha5, 1'b0);
		settle();
		check(cascade_out, 1'b1);
		check(par_out, 8'h00);
		host.latch_pulse();
		settle();
		check(par_out, 8'ha5);
		check(cascade_out, 1'b1);
		rd(8'h04, 32'h0002_a5a5);
		rd(8'h08, 32'h8);
		rd(8'h0c, 32'h1);
		rd(8'h10, 32'h0);
		wr(8'h04, 32'hffff_ffff);
		wr(8'h08, 32'h1);
		rd(8'h08, 32'h0);
		rd(8'h04, 32'h0002_a5a5);
		@(posedge clk);
		drive_enable_n <= 1'b1;
		settle();
		check(par_out_oe, 8'h00);
		check(par_out, 8'ha5);
		rd(8'h04, 32'h0000_a5a5);
		@(posedge clk);
		drive_enable_n <= 1'b0;
		wr(8'h00, 32'h1);
		@(negedge clk);
		check(par_out_oe, 8'h00);
		rd(8'h00, 32'h1);
		wr(8'h00, 32'h0);
		@(negedge clk);
		check(par_out_oe, 8'hff);
		host.frame(8'h3c, 1'b1);
		settle();
		check(par_out, 8'h9e);
		check(cascade_out, 1'b0);
		host.set_clear(1'b0);
		@(negedge clk);
		check(cascade_out, 1'b0);
		check(par_out, 8'h9e);
		host.frame(8'hff, 1'b0);
		host.latch_pulse();
		settle();
		check(par_out, 8'h00);
		check(cascade_out, 1'b0);
		rd(8'h04, 32'h0003_0000);
		host.set_clear(1'b1);
		host.frame(8'h81, 1'b0);
		host.latch_pulse();
		settle();
		check(par_out, 8'h81);
		@(posedge clk);
		ce <= 1'b0;
		rd(8'h0c, 32'h0);
		@(posedge clk);
		ce <= 1'b1;
		rd(8'h0c, 32'hb);
		test_done();
	end
endmodule
